//--- inc/liss_defs.vh
// liss_defs.vh: constants for the line/drive switchover sequencer
// assumes: included by the sequencer module, APB data 32 bits wide
`ifndef LISS_DEFS_VH
`define LISS_DEFS_VH
`define LISS_ADDR_CTRL 12'h000
`define LISS_ADDR_FREQ 12'h004
`define LISS_ADDR_WAIT 12'h008
`define LISS_ADDR_TERM 12'h00C
`define LISS_ADDR_STAT 12'h010
`define LISS_ADDR_CMDF 12'h014
`define LISS_CTRL_SEQ_EN 0
`define LISS_CTRL_ALARM_SW 1
`define LISS_CTRL_RST_ACC 2
`define LISS_CTRL_EXT_MODE 3
`define LISS_CTRL_RESET 32'h0000000D
`define LISS_FREQ_DISABLE 16'h270F
`define LISS_FREQ_RESET 32'h270F270F
`define LISS_BAND_DISABLE 16'h270F
`define LISS_WAIT_RESET 32'h00000014
`define LISS_TERM_RESET 32'h00131211
`define LISS_CODE_IN 8'h11
`define LISS_CODE_MAINS 8'h12
`define LISS_CODE_OUT 8'h13
`define LISS_CODE_W 8
`define LISS_TERM_N 3
`define LISS_SYNC_RESET 7'h10
`define LISS_TICK_NS 100000000
`define LISS_CLK_NS 20
`define LISS_TICK_CYC (`LISS_TICK_NS / `LISS_CLK_NS)
`define LISS_TICK_W 23
`define LISS_FREQ_RANGE 16'h0258
`define LISS_BAND_RANGE 16'h0064
`endif

//--- rtl/liss_sequencer.v
// liss_sequencer.v: line/drive motor contactor switchover sequencer
// assumes: one 50 MHz clock, inputs from terminals are asynchronous, APB slave
`timescale 1ns/1ps
`include "liss_defs.vh"
module liss_sequencer #(
	parameter TICK_CYC = `LISS_TICK_CYC
) (
	// clock and reset
	input wire CLK_SYS_I,
	input wire RST_I,
	// apb slave
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [11:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	output wire PREADY_O,
	output wire PSLVERR_O,
	output reg [31:0] PRDATA_O,
	// terminal inputs
	input wire OPERATION_ENABLE_INPUT_I,
	input wire SWITCHOVER_INPUT_I,
	input wire FORWARD_RUN_INPUT_I,
	input wire REVERSE_RUN_INPUT_I,
	input wire THERMAL_RELAY_INPUT_I,
	input wire STATUS_INIT_INPUT_I,
	input wire DRIVE_ALARM_I,
	// drive status
	input wire [15:0] OUTPUT_FREQ_I,
	// contactor controls and run commands
	output reg INPUT_SIDE_CONTACTOR_O,
	output reg MAINS_MOTOR_CONTACTOR_O,
	output reg OUTPUT_SIDE_CONTACTOR_O,
	output reg RUN_FWD_O,
	output reg RUN_REV_O,
	output reg [2:0] TERMINAL_O
);
	localparam ST_IDLE = 3'h0;
	localparam ST_DRIVE = 3'h1;
	localparam ST_WAIT_MAINS = 3'h2;
	localparam ST_MAINS = 3'h3;
	localparam ST_WAIT_DRIVE = 3'h4;
	localparam ST_START_WAIT = 3'h5;
	localparam ST_ALARM = 3'h6;

	function sel_code;
		input [7:0] code;
		input [7:0] want;
		begin
			sel_code = (code == want);
		end
	endfunction

	// two-flop synchronisers for the seven terminal inputs
	wire [6:0] raw_in = {DRIVE_ALARM_I, STATUS_INIT_INPUT_I, THERMAL_RELAY_INPUT_I,
		REVERSE_RUN_INPUT_I, FORWARD_RUN_INPUT_I, SWITCHOVER_INPUT_I,
		OPERATION_ENABLE_INPUT_I};
	reg [6:0] sync1_reg;
	reg [6:0] sync2_reg;
	always @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			// thermal pin idles high: reset to normal, no false trip
			sync1_reg <= `LISS_SYNC_RESET;
			sync2_reg <= `LISS_SYNC_RESET;
		end else begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
		end
	end
	wire en = sync2_reg[0];
	wire cs = sync2_reg[1];
	wire fwd = sync2_reg[2];
	wire rev = sync2_reg[3];
	wire therm_ok = sync2_reg[4];
	wire init_raw = sync2_reg[5];
	wire alarm = sync2_reg[6];

	// registers
	reg [31:0] ctrl_reg;
	reg [31:0] freq_reg;
	reg [31:0] wait_reg;
	reg [31:0] term_reg;
	reg [15:0] cmd_freq_reg;
	wire seq_en = ctrl_reg[`LISS_CTRL_SEQ_EN];
	wire alarm_sw = ctrl_reg[`LISS_CTRL_ALARM_SW];
	wire rst_acc = ctrl_reg[`LISS_CTRL_RST_ACC];
	wire ext_mode = ctrl_reg[`LISS_CTRL_EXT_MODE];
	wire [15:0] auto_switch_frequency = freq_reg[15:0];
	wire [15:0] auto_return_band = freq_reg[31:16];
	wire [7:0] contactor_wait_time = wait_reg[7:0];
	wire [7:0] start_wait_time = wait_reg[15:8];
	wire active = seq_en && ext_mode;
	wire init = init_raw && rst_acc;

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [7:0] wait_cnt_reg;
	reg [`LISS_TICK_W-1:0] tick_cnt_reg;
	reg fault_reg;
	reg auto_mains_reg;
	wire tick = (tick_cnt_reg == TICK_CYC[`LISS_TICK_W-1:0] - 1'b1);
	wire auto_on = (auto_switch_frequency != `LISS_FREQ_DISABLE);
	wire run = fwd || rev;
	wire at_freq = auto_on && (OUTPUT_FREQ_I >= auto_switch_frequency);
	wire band_on = (auto_return_band != `LISS_BAND_DISABLE);
	wire [16:0] ret_lvl = {1'b0, auto_switch_frequency} - {1'b0, auto_return_band};
	wire below = band_on && !ret_lvl[16] && ({1'b0, cmd_freq_reg} < ret_lvl);
	// auto mains keeps drive off until run stops or command falls back
	wire want_drive = en && cs && !(auto_mains_reg && run && !below);
	wire want_mains = en && !want_drive;

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (want_drive)
					state_next = ST_WAIT_DRIVE;
				else if (want_mains)
					state_next = ST_WAIT_MAINS;
			end
			ST_DRIVE: begin
				if (want_mains || !en)
					state_next = ST_WAIT_MAINS;
			end
			ST_WAIT_MAINS: begin
				if (want_drive)
					state_next = ST_WAIT_DRIVE;
				else if (want_mains && wait_cnt_reg == 8'h00)
					state_next = ST_MAINS;
			end
			ST_MAINS: begin
				if (want_drive)
					state_next = ST_WAIT_DRIVE;
				else if (!en)
					state_next = ST_IDLE;
			end
			ST_WAIT_DRIVE: begin
				if (!want_drive)
					state_next = ST_WAIT_MAINS;
				else if (wait_cnt_reg == 8'h00)
					state_next = ST_START_WAIT;
			end
			ST_START_WAIT: begin
				if (!want_drive)
					state_next = ST_WAIT_MAINS;
				else if (wait_cnt_reg == 8'h00)
					state_next = ST_DRIVE;
			end
			ST_ALARM: begin
				if (!alarm && !fault_reg)
					state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
		// enable off parks in idle so the output contactor holds
		if (!en && state_reg != ST_ALARM)
			state_next = ST_IDLE;
		if (alarm || !therm_ok)
			state_next = ST_ALARM;
		if (init)
			state_next = ST_IDLE;
	end

	always @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			state_reg <= ST_IDLE;
			wait_cnt_reg <= 8'h00;
			tick_cnt_reg <= {`LISS_TICK_W{1'b0}};
			fault_reg <= 1'b0;
			auto_mains_reg <= 1'b0;
		end else if (!active) begin
			state_reg <= ST_IDLE;
			wait_cnt_reg <= 8'h00;
			tick_cnt_reg <= {`LISS_TICK_W{1'b0}};
			fault_reg <= 1'b0;
			auto_mains_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			tick_cnt_reg <= (tick || state_next != state_reg) ? {`LISS_TICK_W{1'b0}} :
				tick_cnt_reg + 1'b1;
			if (state_next == ST_WAIT_DRIVE && state_reg != ST_WAIT_DRIVE)
				wait_cnt_reg <= contactor_wait_time;
			else if (state_next == ST_WAIT_MAINS && state_reg != ST_WAIT_MAINS)
				wait_cnt_reg <= contactor_wait_time;
			else if (state_next == ST_START_WAIT && state_reg != ST_START_WAIT)
				wait_cnt_reg <= start_wait_time;
			else if (tick && wait_cnt_reg != 8'h00)
				wait_cnt_reg <= wait_cnt_reg - 8'h01;
			// alarm latched until reset input accepted
			if (alarm || !therm_ok)
				fault_reg <= 1'b1;
			else if (init)
				fault_reg <= 1'b0;
			if (state_reg == ST_DRIVE && at_freq && run)
				auto_mains_reg <= 1'b1;
			else if (!run || below || !en)
				auto_mains_reg <= 1'b0;
		end
	end

	// contactor outputs
	reg in_c;
	reg mains_c;
	reg out_c;
	always @* begin
		in_c = 1'b1;
		mains_c = 1'b0;
		out_c = OUTPUT_SIDE_CONTACTOR_O;
		if (!active) begin
			in_c = seq_en;
			out_c = seq_en;
		end else if (!therm_ok) begin
			in_c = 1'b0;
			out_c = 1'b0;
		end else if (state_reg == ST_ALARM) begin
			in_c = 1'b0;
			out_c = 1'b0;
			mains_c = alarm_sw && en;
		end else if (init) begin
			in_c = INPUT_SIDE_CONTACTOR_O;
		end else begin
			mains_c = (state_reg == ST_MAINS);
			case (state_reg)
				ST_DRIVE, ST_START_WAIT: out_c = 1'b1;
				ST_IDLE: out_c = OUTPUT_SIDE_CONTACTOR_O;
				default: out_c = 1'b0;
			endcase
		end
		if (mains_c)
			out_c = 1'b0;
	end

	// terminal k shows the contactor whose code sits in byte k
	wire [`LISS_TERM_N-1:0] term_next;
	genvar gi;
	generate
		for (gi = 0; gi < `LISS_TERM_N; gi = gi + 1) begin : g_term
			wire [`LISS_CODE_W-1:0] code;
			assign code = term_reg[gi*`LISS_CODE_W +: `LISS_CODE_W];
			assign term_next[gi] = sel_code(code, `LISS_CODE_IN) ? INPUT_SIDE_CONTACTOR_O :
				sel_code(code, `LISS_CODE_MAINS) ? MAINS_MOTOR_CONTACTOR_O :
				sel_code(code, `LISS_CODE_OUT) && OUTPUT_SIDE_CONTACTOR_O;
		end
	endgenerate

	always @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			INPUT_SIDE_CONTACTOR_O <= 1'b0;
			MAINS_MOTOR_CONTACTOR_O <= 1'b0;
			OUTPUT_SIDE_CONTACTOR_O <= 1'b0;
			RUN_FWD_O <= 1'b0;
			RUN_REV_O <= 1'b0;
			TERMINAL_O <= 3'h0;
		end else begin
			INPUT_SIDE_CONTACTOR_O <= in_c;
			MAINS_MOTOR_CONTACTOR_O <= mains_c && !OUTPUT_SIDE_CONTACTOR_O;
			OUTPUT_SIDE_CONTACTOR_O <= out_c && !MAINS_MOTOR_CONTACTOR_O;
			RUN_FWD_O <= (!active || (en && cs)) && state_reg == ST_DRIVE && fwd;
			RUN_REV_O <= (!active || (en && cs)) && state_reg == ST_DRIVE && rev && !fwd;
			TERMINAL_O <= term_next;
		end
	end

	// apb slave, zero wait states
	wire wr = PSEL_I && PENABLE_I && PWRITE_I;
	wire mapped = (PADDR_I == `LISS_ADDR_CTRL) || (PADDR_I == `LISS_ADDR_FREQ) ||
		(PADDR_I == `LISS_ADDR_WAIT) || (PADDR_I == `LISS_ADDR_TERM) ||
		(PADDR_I == `LISS_ADDR_STAT) || (PADDR_I == `LISS_ADDR_CMDF);
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
	always @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			ctrl_reg <= `LISS_CTRL_RESET;
			freq_reg <= `LISS_FREQ_RESET;
			wait_reg <= `LISS_WAIT_RESET;
			term_reg <= `LISS_TERM_RESET;
			cmd_freq_reg <= 16'h0000;
			PRDATA_O <= 32'h00000000;
		end else begin
			if (wr && PADDR_I == `LISS_ADDR_CTRL)
				ctrl_reg <= {28'h0000000, PWDATA_I[3:0]};
			if (wr && PADDR_I == `LISS_ADDR_FREQ)
				freq_reg <= PWDATA_I;
			if (wr && PADDR_I == `LISS_ADDR_WAIT)
				wait_reg <= {16'h0000, PWDATA_I[15:0]};
			if (wr && PADDR_I == `LISS_ADDR_TERM)
				term_reg <= {8'h00, PWDATA_I[23:0]};
			if (wr && PADDR_I == `LISS_ADDR_CMDF)
				cmd_freq_reg <= PWDATA_I[15:0];
			if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
				case (PADDR_I)
					`LISS_ADDR_CTRL: PRDATA_O <= ctrl_reg;
					`LISS_ADDR_FREQ: PRDATA_O <= freq_reg;
					`LISS_ADDR_WAIT: PRDATA_O <= wait_reg;
					`LISS_ADDR_TERM: PRDATA_O <= term_reg;
					`LISS_ADDR_STAT: PRDATA_O <= {16'h0000, wait_cnt_reg, sync2_reg[6:5],
						auto_mains_reg, fault_reg, 1'b0, state_reg};
					`LISS_ADDR_CMDF: PRDATA_O <= {16'h0000, cmd_freq_reg};
					default: PRDATA_O <= 32'h00000000;
				endcase
			end
		end
	end
endmodule

//--- tb/liss_seq_chk.sv
// liss_seq_chk.sv: port assertions for the switchover sequencer
// assumes: bound to liss_sequencer, sequence enable, external mode and reset accept left set
`timescale 1ns/1ps
module liss_seq_chk (
	// clock and reset
	input wire CLK_SYS_I,
	input wire RST_I,
	// terminal inputs
	input wire OPERATION_ENABLE_INPUT_I,
	input wire SWITCHOVER_INPUT_I,
	input wire THERMAL_RELAY_INPUT_I,
	input wire STATUS_INIT_INPUT_I,
	input wire DRIVE_ALARM_I,
	// contactor controls and run commands
	input wire INPUT_SIDE_CONTACTOR_O,
	input wire MAINS_MOTOR_CONTACTOR_O,
	input wire OUTPUT_SIDE_CONTACTOR_O,
	input wire RUN_FWD_O,
	input wire RUN_REV_O
);
	wire [4:0] cond = {OPERATION_ENABLE_INPUT_I, SWITCHOVER_INPUT_I, THERMAL_RELAY_INPUT_I,
		DRIVE_ALARM_I, STATUS_INIT_INPUT_I};
	reg [4:0] cond_reg;
	reg [7:0] cnt_reg;
	wire [7:0] cnt_next = (cond != cond_reg) ? 8'h00 : cnt_reg + {7'h00, cnt_reg != 8'hFF};
	// cycles the enable, switchover, thermal, alarm and init inputs have stayed unchanged
	always @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			cond_reg <= 5'h00;
			cnt_reg <= 8'h00;
		end else begin
			cond_reg <= cond;
			cnt_reg <= cnt_next;
		end
	end
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	a_mains_out_excl: assert property (
		!(MAINS_MOTOR_CONTACTOR_O && OUTPUT_SIDE_CONTACTOR_O))
		else $error("mains and output contactors closed together");
	a_thermal_opens_all: assert property (
		!THERMAL_RELAY_INPUT_I [*8] |->
		!INPUT_SIDE_CONTACTOR_O && !MAINS_MOTOR_CONTACTOR_O && !OUTPUT_SIDE_CONTACTOR_O)
		else $error("contactor closed during thermal fault");
	a_enable_off_mains: assert property (
		!OPERATION_ENABLE_INPUT_I [*8] |-> !MAINS_MOTOR_CONTACTOR_O)
		else $error("mains closed while disabled");
	a_init_holds: assert property (
		(STATUS_INIT_INPUT_I && THERMAL_RELAY_INPUT_I && !DRIVE_ALARM_I) [*8] |->
		!MAINS_MOTOR_CONTACTOR_O && $stable(INPUT_SIDE_CONTACTOR_O) &&
		$stable(OUTPUT_SIDE_CONTACTOR_O))
		else $error("init did not hold contactors");
	a_alarm_opens: assert property (
		DRIVE_ALARM_I [*8] |-> !INPUT_SIDE_CONTACTOR_O && !OUTPUT_SIDE_CONTACTOR_O)
		else $error("contactor closed during alarm");
	a_run_needs_sw: assert property (
		(!SWITCHOVER_INPUT_I || !OPERATION_ENABLE_INPUT_I) [*8] |-> !RUN_FWD_O && !RUN_REV_O)
		else $error("run command outside drive operation");
	a_drive_mode: assert property (
		cnt_reg == 8'h78 && cond == 5'h1C |->
		INPUT_SIDE_CONTACTOR_O && OUTPUT_SIDE_CONTACTOR_O && !MAINS_MOTOR_CONTACTOR_O)
		else $error("drive operation not reached");
	a_mains_mode: assert property (
		cnt_reg == 8'h78 && cond == 5'h14 |->
		INPUT_SIDE_CONTACTOR_O && MAINS_MOTOR_CONTACTOR_O && !OUTPUT_SIDE_CONTACTOR_O)
		else $error("mains operation not reached");
endmodule

//--- tb/liss_contactor_model.sv
// liss_contactor_model.sv: contactors, motor and thermal relay
// assumes: bench requests motor faults on fault_i
`timescale 1ns/1ps
module liss_contactor_model (
	input wire clk_i,
	input wire fault_i,
	input wire in_i,
	input wire mains_i,
	input wire out_i,
	output reg thermal_ok_o,
	output reg motor_mains_o,
	output reg motor_drive_o
);
	initial thermal_ok_o = 1'b1;
	always @(posedge clk_i) begin
		thermal_ok_o <= !fault_i;
		motor_mains_o <= mains_i && !out_i;
		motor_drive_o <= out_i && in_i && !mains_i;
	end
endmodule

//--- tb/line_inverter_switchover_sequencer_tb.sv
// line_inverter_switchover_sequencer_tb.sv: self-checking bench
// assumes: TICK_CYC shortened to 4 clocks
`timescale 1ns/1ps
`include "liss_defs.vh"
`define LISS_CMP(nm, x, g) begin num_checks++; if ((g) !== (x)) begin num_errors++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, x, g); end end
module line_inverter_switchover_sequencer_tb;
	reg clk, rst, psel, pen, pwr, en, sw, fwd, rev, init, alarm, fault_req, samp, fhi;
	wire [2:0] term;
	reg [11:0] paddr;
	reg [31:0] pwdata, rnd, wv;
	reg [15:0] freq;
	wire pready, pslverr, therm, c_in, c_mains, c_out, r_fwd, r_rev;
	wire [31:0] prdata;
	logic [37:0] exp_q[$];
	logic [37:0] e;
	int num_errors = 0;
	int num_checks = 0;
	liss_sequencer #(.TICK_CYC(4)) uut (.CLK_SYS_I(clk), .RST_I(rst), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .PRDATA_O(prdata),
		.OPERATION_ENABLE_INPUT_I(en), .SWITCHOVER_INPUT_I(sw), .FORWARD_RUN_INPUT_I(fwd),
		.REVERSE_RUN_INPUT_I(rev), .THERMAL_RELAY_INPUT_I(therm),
		.STATUS_INIT_INPUT_I(init), .DRIVE_ALARM_I(alarm), .OUTPUT_FREQ_I(freq),
		.INPUT_SIDE_CONTACTOR_O(c_in), .MAINS_MOTOR_CONTACTOR_O(c_mains),
		.OUTPUT_SIDE_CONTACTOR_O(c_out), .RUN_FWD_O(r_fwd), .RUN_REV_O(r_rev), .TERMINAL_O(term));
	liss_contactor_model mdl (.clk_i(clk), .fault_i(fault_req), .in_i(c_in),
		.mains_i(c_mains), .out_i(c_out), .thermal_ok_o(therm), .motor_mains_o(),
		.motor_drive_o());
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	task summarize;
		begin
			if (num_errors == 0 && num_checks > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
		begin
			psel <= 1'b1;
			pwr <= w;
			paddr <= a;
			pwdata <= d;
			if (!w)
				exp_q.push_back({5'h00, x});
			@(posedge clk);
			pen <= 1'b1;
			@(posedge clk);
			while (!pready) @(posedge clk);
			psel <= 1'b0;
			pen <= 1'b0;
			@(posedge clk);
		end
	endtask
	// inputs {en,sw,fwd,rev,init,alarm,fault}, outputs {in,mains,out,fwd,rev}
	task step(input logic [6:0] c, input logic [4:0] x, input logic [4:0] m);
		begin
			{en, sw, fwd, rev, init, alarm, fault_req} <= c;
			rnd = xs(rnd);
			freq <= fhi ? (`LISS_FREQ_RANGE + {8'h00, rnd[7:0]}) : (rnd[15:0] % `LISS_FREQ_RANGE);
			repeat (150) @(posedge clk);
			exp_q.push_back({1'b1, m, 27'h0, x & m});
			samp <= 1'b1;
			@(posedge clk);
			samp <= 1'b0;
		end
	endtask
	always @(posedge clk) begin
		if ((psel && pen && pready && !pwr) || samp) begin
			e = exp_q.pop_front();
			if (e[37]) begin
				`LISS_CMP("contactors", e[4:0], {c_in, c_mains, c_out, r_fwd, r_rev} & e[36:32])
				`LISS_CMP("terminals", {e[2], e[3], e[4]}, term & {e[34], e[35], e[36]})
			end else
				`LISS_CMP("apb read", e[32:0], {pslverr, prdata})
		end
	end
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#200000;
		num_errors++;
		summarize;
	end
	initial begin
		rnd = 32'hFA5FEF0D;
		fhi = 1'b0;
		{rst, psel, pen, pwr, paddr, pwdata, freq, samp} <= {1'b1, 64'h0};
		{en, sw, fwd, rev, init, alarm, fault_req} <= 7'h00;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, `LISS_ADDR_CTRL, 32'h0, {1'b0, `LISS_CTRL_RESET});
		apb(1'b0, `LISS_ADDR_TERM, 32'h0, {1'b0, `LISS_TERM_RESET});
		apb(1'b0, 12'h020, 32'h0, 33'h100000000);
		rnd = xs(rnd);
		wv = (rnd & 32'h00000303) | 32'h00000101;
		apb(1'b1, `LISS_ADDR_WAIT, wv, 33'h0);
		apb(1'b0, `LISS_ADDR_WAIT, 32'h0, {1'b0, wv});
		step(7'b0000000, 5'b10000, 5'b11011);
		step(7'b1000000, 5'b11000, 5'b11111);
		step(7'b1100000, 5'b10100, 5'b11111);
		step(7'b1110000, 5'b10110, 5'b11111);
		step(7'b1101000, 5'b10101, 5'b11111);
		step(7'b1110100, 5'b10100, 5'b11100);
		step(7'b1010000, 5'b11000, 5'b11111);
		step(7'b0110000, 5'b10000, 5'b11111);
		step(7'b1100001, 5'b00000, 5'b11100);
		step(7'b1100100, 5'b00000, 5'b01000);
		step(7'b1100000, 5'b10100, 5'b11111);
		step(7'b1100010, 5'b00000, 5'b11100);
		step(7'b1100100, 5'b00000, 5'b01000);
		step(7'b1100000, 5'b10100, 5'b11111);
		step(7'b0100000, 5'b10100, 5'b11111);
		apb(1'b1, `LISS_ADDR_FREQ, {`LISS_BAND_RANGE, `LISS_FREQ_RANGE}, 33'h0);
		apb(1'b1, `LISS_ADDR_CMDF, 32'h00000258, 33'h0);
		step(7'b1110000, 5'b10110, 5'b11111);
		fhi = 1'b1;
		step(7'b1110000, 5'b11000, 5'b11111);
		fhi = 1'b0;
		apb(1'b1, `LISS_ADDR_CMDF, 32'h00000000, 33'h0);
		step(7'b1110000, 5'b10110, 5'b11111);
		apb(1'b1, `LISS_ADDR_CTRL, 32'h0000000F, 33'h0);
		step(7'b1100010, 5'b01000, 5'b11100);
		step(7'b1100100, 5'b00000, 5'b01000);
		apb(1'b1, `LISS_ADDR_CTRL, 32'h00000005, 33'h0);
		step(7'b1100000, 5'b10100, 5'b11111);
		summarize;
	end
endmodule
bind liss_sequencer liss_seq_chk u_chk (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
	.OPERATION_ENABLE_INPUT_I(OPERATION_ENABLE_INPUT_I),
	.SWITCHOVER_INPUT_I(SWITCHOVER_INPUT_I), .THERMAL_RELAY_INPUT_I(THERMAL_RELAY_INPUT_I),
	.STATUS_INIT_INPUT_I(STATUS_INIT_INPUT_I), .DRIVE_ALARM_I(DRIVE_ALARM_I),
	.INPUT_SIDE_CONTACTOR_O(INPUT_SIDE_CONTACTOR_O),
	.MAINS_MOTOR_CONTACTOR_O(MAINS_MOTOR_CONTACTOR_O),
	.OUTPUT_SIDE_CONTACTOR_O(OUTPUT_SIDE_CONTACTOR_O), .RUN_FWD_O(RUN_FWD_O),
	.RUN_REV_O(RUN_REV_O));
